// ### rwtb_pkg.sv
// Package for the result window threshold bank: offsets, layouts, types.
// Assumes a register access port in the core_clk domain.
`default_nettype none
package rwtb_pkg;
	localparam int unsigned         LIM_W         = 24;
	localparam int unsigned         ADDR_W        = 8;
	localparam int unsigned         NUM_LIM       = 6;
	localparam logic [ADDR_W-1:0]   OFS_LOWER6    = 8'h26;
	localparam logic [ADDR_W-1:0]   OFS_LOWER7    = 8'h27;
	localparam logic [ADDR_W-1:0]   OFS_UPPER0    = 8'h28;
	localparam logic [ADDR_W-1:0]   OFS_UPPER1    = 8'h29;
	localparam logic [ADDR_W-1:0]   OFS_UPPER2    = 8'h2a;
	localparam logic [ADDR_W-1:0]   OFS_UPPER3    = 8'h2b;
	localparam logic [LIM_W-1:0]    LIM_RESET     = 24'h000000;
	// Limit slot index in the memory: 0,1 lower 6/7; 2..5 upper 0..3
	localparam logic [2:0]          IDX_LOWER6    = 3'h0;
	localparam logic [2:0]          IDX_LOWER7    = 3'h1;
	localparam logic [2:0]          IDX_UPPER0    = 3'h2;
	localparam logic [2:0]          IDX_UPPER3    = 3'h5;

	typedef struct packed {
		logic                 wr;
		logic                 rd;
		logic [ADDR_W-1:0]    addr;
		logic [LIM_W-1:0]     wdata;
	} rwtb_req_t;

	typedef struct packed {
		logic                 valid;
		logic                 hit;
		logic [LIM_W-1:0]     rdata;
	} rwtb_rsp_t;

	// Result slot update: slot number 0..7 and the new code
	typedef struct packed {
		logic                 valid;
		logic [2:0]           slot;
		logic [LIM_W-1:0]     code;
	} rwtb_result_t;

	// Flag bits: [0..3] over-range slots 0..3, [4] under 6, [5] under 7
	typedef struct packed {
		logic                 under_range_flag_slot7;
		logic                 under_range_flag_slot6;
		logic                 over_range_flag_slot3;
		logic                 over_range_flag_slot2;
		logic                 over_range_flag_slot1;
		logic                 over_range_flag_slot0;
	} rwtb_flags_t;
endpackage : rwtb_pkg
`default_nettype wire

// ### rwtb_limit_mem.sv
// Small limit store: one write port, two registered read ports.
// Assumes one clock and a synchronous reset that clears every word.
`timescale 1ns/1ps
`default_nettype none
module rwtb_limit_mem #(
	parameter int unsigned DEPTH = 6,
	parameter int unsigned WIDTH = 24
) (
	// Clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      srst,
	// Write port
	input  wire logic                      we,
	input  wire logic [2:0]                waddr,
	input  wire logic [WIDTH-1:0]          wdata,
	// Software read port
	input  wire logic [2:0]                raddr_a,
	output var  logic [WIDTH-1:0]          rdata_a,
	// Comparator read port
	input  wire logic [2:0]                raddr_b,
	output var  logic [WIDTH-1:0]          rdata_b
);
	initial begin
		if (DEPTH < 1 || DEPTH > 8)
			$error("rwtb_limit_mem: DEPTH must be 1..8");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0]            ra;
		logic [WIDTH-1:0]            rb;
	} rwtb_mem_st_t;

	rwtb_mem_st_t st_r;
	rwtb_mem_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (we && (32'(waddr) < DEPTH))
			st_nxt.mem[waddr] = wdata;
		st_nxt.ra = (32'(raddr_a) < DEPTH) ? st_r.mem[raddr_a] : '0;
		st_nxt.rb = (32'(raddr_b) < DEPTH) ? st_r.mem[raddr_b] : '0;
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign rdata_a = st_r.ra;
	assign rdata_b = st_r.rb;
endmodule : rwtb_limit_mem
`default_nettype wire

// ### rwtb_bank.sv
// Result window threshold bank: six 24-bit limits and their range flags.
// Assumes requests and result updates arrive on core_clk from the core.
`timescale 1ns/1ps
`default_nettype none
module rwtb_bank #(
	parameter int unsigned LIM_W = rwtb_pkg::LIM_W
) (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   srst,
	// Register access
	input  wire rwtb_pkg::rwtb_req_t    req,
	output var  rwtb_pkg::rwtb_rsp_t    rsp,
	// Coding settings
	input  wire logic                   unipolar_bipolar_select,
	input  wire logic                   format_offset_binary,
	// Result slot updates
	input  wire rwtb_pkg::rwtb_result_t result,
	// Range flags
	output var  rwtb_pkg::rwtb_flags_t  flags
);
	initial begin
		if (LIM_W != rwtb_pkg::LIM_W)
			$error("rwtb_bank: LIM_W must equal the package width");
	end

	// Map a register offset to a memory index; bit 3 flags a miss
	function automatic logic [3:0] ofs_to_idx(input logic [7:0] a);
		case (a)
			rwtb_pkg::OFS_LOWER6: ofs_to_idx = {1'b0, rwtb_pkg::IDX_LOWER6};
			rwtb_pkg::OFS_LOWER7: ofs_to_idx = {1'b0, rwtb_pkg::IDX_LOWER7};
			rwtb_pkg::OFS_UPPER0: ofs_to_idx = 4'h2;
			rwtb_pkg::OFS_UPPER1: ofs_to_idx = 4'h3;
			rwtb_pkg::OFS_UPPER2: ofs_to_idx = 4'h4;
			rwtb_pkg::OFS_UPPER3: ofs_to_idx = {1'b0, rwtb_pkg::IDX_UPPER3};
			default:              ofs_to_idx = 4'h8;
		endcase
	endfunction : ofs_to_idx

	// Put a code on a common signed scale.  Bipolar codes are two's
	// complement unless offset binary is chosen; unipolar codes are
	// straight binary, so a zero sign extension keeps them positive.
	function automatic logic signed [LIM_W:0] to_scale(
		input logic [LIM_W-1:0] c,
		input logic             bip,
		input logic             offs);
		if (!bip)
			to_scale = {1'b0, c};
		else if (offs)
			to_scale = {~c[LIM_W-1], ~c[LIM_W-1], c[LIM_W-2:0]};
		else
			to_scale = {c[LIM_W-1], c};
	endfunction : to_scale

	// Slot number to limit index; bit 3 marks a slot with no limit here
	function automatic logic [3:0] slot_to_idx(input logic [2:0] s);
		case (s)
			3'h0, 3'h1, 3'h2, 3'h3: slot_to_idx = {1'b0, s + 3'h2};
			3'h6:                   slot_to_idx = 4'h0;
			3'h7:                   slot_to_idx = 4'h1;
			default:                slot_to_idx = 4'h8;
		endcase
	endfunction : slot_to_idx

	typedef enum logic [1:0] {
		CMP_IDLE = 2'b01,
		CMP_EVAL = 2'b10
	} rwtb_cmp_state_t;

	typedef struct packed {
		rwtb_cmp_state_t        state;
		logic [2:0]             slot;
		logic [LIM_W-1:0]       code;
		logic                   rd_pend;
		logic                   rd_hit;
		rwtb_pkg::rwtb_flags_t  flags;
	} rwtb_bank_st_t;

	rwtb_bank_st_t st_r;
	rwtb_bank_st_t st_nxt;

	logic [3:0]       wr_idx;
	logic [3:0]       rd_idx;
	logic [3:0]       res_idx;
	logic [LIM_W-1:0] sw_rdata;
	logic [LIM_W-1:0] lim_rdata;
	logic [3:0]       cmp_idx;
	logic             is_lower;
	logic             crossed;
	logic [5:0]       flag_vec;

	assign wr_idx  = ofs_to_idx(req.addr);
	assign rd_idx  = ofs_to_idx(req.addr);
	assign res_idx = slot_to_idx(result.slot);
	assign cmp_idx = slot_to_idx(st_r.slot);

	// Limits are held as written; the coding is applied at compare time
	rwtb_limit_mem #(
		.DEPTH (rwtb_pkg::NUM_LIM),
		.WIDTH (LIM_W)
	) u_mem (
		.core_clk (core_clk),
		.srst     (srst),
		.we       (req.wr && !wr_idx[3]),
		.waddr    (wr_idx[2:0]),
		.wdata    (req.wdata),
		.raddr_a  (rd_idx[2:0]),
		.rdata_a  (sw_rdata),
		.raddr_b  (res_idx[2:0]),
		.rdata_b  (lim_rdata)
	);

	// Slots 6 and 7 use a lower limit, slots 0..3 an upper one
	assign is_lower = (st_r.slot == 3'h6) || (st_r.slot == 3'h7);

	always_comb begin
		crossed = 1'b0;
		if (is_lower)
			crossed = to_scale(st_r.code, unipolar_bipolar_select,
				format_offset_binary) < to_scale(lim_rdata,
				unipolar_bipolar_select, format_offset_binary);
		else
			crossed = to_scale(st_r.code, unipolar_bipolar_select,
				format_offset_binary) > to_scale(lim_rdata,
				unipolar_bipolar_select, format_offset_binary);
	end

	always_comb begin
		st_nxt         = st_r;
		st_nxt.rd_pend = req.rd;
		st_nxt.rd_hit  = req.rd && !rd_idx[3];
		flag_vec       = st_r.flags;
		case (st_r.state)
			CMP_IDLE: begin
				if (result.valid && !res_idx[3]) begin
					st_nxt.slot  = result.slot;
					st_nxt.code  = result.code;
					st_nxt.state = CMP_EVAL;
				end
			end
			CMP_EVAL: begin
				// Flag reflects the latest accepted result of its slot
				flag_vec[cmp_idx[2:0] == 3'h0 ? 4 :
					cmp_idx[2:0] == 3'h1 ? 5 :
					32'(cmp_idx[2:0]) - 2] = crossed;
				st_nxt.state = CMP_IDLE;
			end
			default: st_nxt.state = CMP_IDLE;
		endcase
		st_nxt.flags = flag_vec;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_r       <= '0;
			st_r.state <= CMP_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Unmapped reads answer with zero data and hit low
	// One driver for the whole response word keeps the variable single-sourced
	assign rsp = {st_r.rd_pend, st_r.rd_hit,
		st_r.rd_hit ? sw_rdata : {LIM_W{1'b0}}};
	assign flags     = st_r.flags;
endmodule : rwtb_bank
`default_nettype wire

// ### rwtb_chk.sv
// Port checker for the threshold bank.
// Assumes one clock domain; bound to rwtb_bank below.
`timescale 1ns/1ps
`default_nettype none
module rwtb_chk (
	// Clock and reset
	input wire logic                   core_clk,
	input wire logic                   srst,
	// Register access
	input wire rwtb_pkg::rwtb_req_t    req,
	input wire rwtb_pkg::rwtb_rsp_t    rsp,
	// Coding and results
	input wire logic                   unipolar_bipolar_select,
	input wire logic                   format_offset_binary,
	input wire rwtb_pkg::rwtb_result_t result,
	input wire rwtb_pkg::rwtb_flags_t  flags
);
	logic map;
	assign map = req.addr inside {[8'h26:8'h2b]};
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (srst);
	// Idle cycle first, so the comparator cannot be busy
	sequence s_take;
		!result.valid ##1 result.valid;
	endsequence
	sequence s_wr_rd;
		req.wr && !req.rd && map ##1 req.rd && !req.wr && $stable(req.addr);
	endsequence
	property p_rd_lat;
		req.rd |=> rsp.valid && rsp.hit == $past(map);
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("bad read answer");
	property p_no_rd;
		!req.rd |=> !rsp.valid;
	endproperty
	a_no_rd: assert property (p_no_rd) else $error("stray answer");
	property p_miss;
		req.rd && !map |=> rsp.rdata == 24'h0;
	endproperty
	a_miss: assert property (p_miss) else $error("miss data");
	property p_wr_rd;
		s_wr_rd |=> rsp.rdata == $past(req.wdata, 2);
	endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("readback");
	// Three quiet cycles covers either update edge
	property p_hold;
		!result.valid [*3] |=> $stable(flags);
	endproperty
	a_hold: assert property (p_hold) else $error("flags moved");
	property p_over0;
		s_take ##0 (result.slot == 3'h0 && result.code == 24'h0
			&& !unipolar_bipolar_select) |-> ##3 !flags.over_range_flag_slot0;
	endproperty
	a_over0: assert property (p_over0) else $error("over0 set");
	property p_under6;
		s_take ##0 (result.slot == 3'h6 && result.code == 24'hffffff
			&& !unipolar_bipolar_select) |-> ##3 !flags.under_range_flag_slot6;
	endproperty
	a_under6: assert property (p_under6) else $error("under6 set");
	property p_over1_bip;
		s_take ##0 (result.slot == 3'h1 && result.code == 24'h800000
			&& unipolar_bipolar_select && !format_offset_binary)
			|-> ##3 !flags.over_range_flag_slot1;
	endproperty
	a_over1_bip: assert property (p_over1_bip) else $error("over1 set");
endmodule : rwtb_chk
bind rwtb_bank rwtb_chk rwtb_chk_i (
	.core_clk(core_clk),
	.srst(srst),
	.req(req),
	.rsp(rsp),
	.unipolar_bipolar_select(unipolar_bipolar_select),
	.format_offset_binary(format_offset_binary),
	.result(result),
	.flags(flags)
);
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the threshold bank.
// Assumes rwtb_bank with its checker bound; inputs move at falling edges.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic                   core_clk;
	logic                   srst;
	rwtb_pkg::rwtb_req_t    req;
	rwtb_pkg::rwtb_rsp_t    rsp;
	logic                   unipolar_bipolar_select;
	logic                   format_offset_binary;
	rwtb_pkg::rwtb_result_t result;
	rwtb_pkg::rwtb_flags_t  flags;
	int                     n_errors;
	int                     checked;
	int                     cyc;
	rwtb_bank rwtb_bank_i (
		.core_clk(core_clk),
		.srst(srst),
		.req(req),
		.rsp(rsp),
		.unipolar_bipolar_select(unipolar_bipolar_select),
		.format_offset_binary(format_offset_binary),
		.result(result),
		.flags(flags)
	);
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// Whole run is near 120 cycles
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			n_errors++;
			end_sim();
		end
	end
	task automatic chk(input string nm, input logic [23:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Request stays up a full cycle; caller releases it with rel
	task automatic acc(input logic w, r, input logic [7:0] a,
		input logic [23:0] d, input logic h);
		req = {w, r, a, d};
		@(negedge core_clk);
		if (r) begin
			chk("hit", {23'h0, rsp.valid & rsp.hit}, {23'h0, h});
			chk("rdata", rsp.rdata, d);
		end
	endtask : acc
	task automatic rel;
		req = '0;
		@(negedge core_clk);
	endtask : rel
	task automatic res(input int s, input logic [23:0] c, input logic e);
		int b;
		b = s > 5 ? s - 2 : s;
		result = {1'b1, 3'(s), c};
		@(negedge core_clk);
		result.valid = 1'b0;
		repeat (2) @(negedge core_clk);
		chk("flag", {23'h0, flags[b]}, {23'h0, e});
	endtask : res
	task automatic t_regs;
		for (int i = 0; i < 6; i++) begin
			acc(1'b0, 1'b1, 8'h26 + 8'(i), 24'h0, 1'b1);
			acc(1'b1, 1'b0, 8'h26 + 8'(i), ~24'(i), 1'b0);
			acc(1'b0, 1'b1, 8'h26 + 8'(i), ~24'(i), 1'b1);
		end
		for (int i = 0; i < 6; i++) begin
			acc(1'b0, 1'b1, 8'h26 + 8'(i), ~24'(i), 1'b1);
		end
		acc(1'b1, 1'b0, 8'h25, 24'hffffff, 1'b0);
		acc(1'b0, 1'b1, 8'h25, 24'h0, 1'b0);
		rel();
		$display("t_regs done");
	endtask : t_regs
	// Limit 0x100 everywhere; equal codes must not flag
	task automatic t_flags;
		int s;
		for (int i = 0; i < 6; i++) begin
			acc(1'b1, 1'b0, 8'h26 + 8'(i), 24'h000100, 1'b0);
		end
		rel();
		for (int i = 0; i < 6; i++) begin
			s = i < 2 ? i + 6 : i - 2;
			res(s, i < 2 ? 24'h0000ff : 24'h000101, 1'b1);
			res(s, 24'h000100, 1'b0);
			res(s, i < 2 ? 24'hffffff : 24'h0, 1'b0);
		end
		$display("t_flags done");
	endtask : t_flags
	task automatic t_coding;
		for (int m = 0; m < 3; m++) begin
			unipolar_bipolar_select = m != 0;
			format_offset_binary = m == 2;
			acc(1'b1, 1'b0, 8'h29, 24'h000010, 1'b0);
			rel();
			res(1, 24'h800000, m != 1);
		end
		unipolar_bipolar_select = 1'b0;
		format_offset_binary = 1'b0;
		$display("t_coding done");
	endtask : t_coding
	// Busy comparator drops the next result; a slot 4 result is ignored
	task automatic t_busy;
		result = {1'b1, 3'h0, 24'h000101};
		@(negedge core_clk);
		result = {1'b1, 3'h2, 24'h000101};
		@(negedge core_clk);
		result = {1'b1, 3'h4, 24'hffffff};
		@(negedge core_clk);
		result.valid = 1'b0;
		repeat (2) @(negedge core_clk);
		chk("over0", {23'h0, flags.over_range_flag_slot0}, 24'h1);
		chk("over2", {23'h0, flags.over_range_flag_slot2}, 24'h0);
		chk("flags", {18'h0, flags}, 24'h000003);
		$display("t_busy done");
	endtask : t_busy
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		n_errors = 0;
		checked = 0;
		cyc = 0;
		srst = 1'b1;
		req = '0;
		result = '0;
		unipolar_bipolar_select = 1'b0;
		format_offset_binary = 1'b0;
		repeat (8) @(negedge core_clk);
		srst = 1'b0;
		t_regs();
		t_flags();
		t_coding();
		t_busy();
		end_sim();
	end
endmodule : testbench
`default_nettype wire
